/* File: logic/brb_bank.sv */
`timescale 1ns/1ps
module brb_bank import brb_pkg::*; #(
	// Identification bytes; the values are arbitrary.
	parameter logic [7:0] REVISION_CODE = 8'h5a,
	parameter logic [7:0] PART_CODE     = 8'ha5
) (
	// Clock, reset, enable
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        ce,
	// Serial port side
	input  wire logic        sp_rd,
	input  wire logic        sp_wr,
	input  wire logic [15:0] sp_addr,
	input  wire logic [7:0]  sp_wdata,
	output logic      [7:0]  sp_rdata,
	output logic             sp_rvalid,
	// Storage controller side
	input  wire logic        ee_busy,
	input  wire logic        ee_rd,
	input  wire logic        ee_wr,
	input  wire logic [15:0] ee_addr,
	input  wire logic [7:0]  ee_wdata,
	output logic      [7:0]  ee_rdata,
	output logic             ee_rvalid,
	// Pin and internal functions
	input  wire logic        multifunction_pin_zero,
	input  wire logic        action_done,
	input  wire logic [7:0]  status_in,
	output logic      [7:0]  port_cfg,
	output logic      [7:0]  s_ctl_act,
	output logic      [7:0]  direct_out,
	output logic             action_act,
	output logic      [15:0] c_param_act,
	output logic             update_busy
);
	// Live registers.
	logic [7:0]  port_cfg_r;
	logic [7:0]  rb_sel_r;
	logic [7:0]  pin_zero_r;
	logic        xfer_req_r;
	logic [7:0]  seq_r [SEQ_DEPTH];
	// Buffered and active copies.
	logic [7:0]  s_ctl_buf_r;
	logic [7:0]  s_ctl_act_r;
	logic [7:0]  direct_r;
	logic        action_buf_r;
	logic        action_act_r;
	logic [15:0] c_buf_r;
	logic [15:0] c_act_r;
	logic [7:0]  status_act_r;
	// Update path.
	logic        pin_s1_r;
	logic        pin_s2_r;
	logic        pin_s3_r;
	logic        req_s1_r;
	logic        req_s2_r;
	logic        c_stage_r;
	logic [DIV_W-1:0] div_r;
	brb_upd_t    upd_r;
	brb_upd_t    upd_nxt;
	// Read answers.
	logic [7:0]  sp_rdata_r;
	logic        sp_rvalid_r;
	logic [7:0]  ee_rdata_r;
	logic        ee_rvalid_r;

	function automatic logic is_seq(input logic [15:0] a);
		is_seq = (a >= ADR_SEQ_FIRST) && (a <= ADR_SEQ_LAST); // R03
	endfunction

	function automatic logic is_ro(input logic [15:0] a);
		is_ro = (a == ADR_REVISION) || (a == ADR_PART_ID) || (a == ADR_STATUS);
	endfunction

	// Registers kept away from the storage controller, read-only ones included.
	function automatic logic is_ee_excl(input logic [15:0] a);
		is_ee_excl = (a <= ADR_XFER_TRIG) || is_seq(a) || is_ro(a); // R17
	endfunction

	function automatic logic [SEQ_IDX_W-1:0] seq_idx(input logic [15:0] a);
		logic [15:0] d;
		d = a - ADR_SEQ_FIRST;
		seq_idx = d[SEQ_IDX_W-1:0];
	endfunction

	// Readback mux; anything unmapped reads as zero.
	function automatic logic [7:0] rd_byte(input logic [15:0] a, input logic sel_buf);
		rd_byte = 8'h00; // R14
		if (is_seq(a)) begin
			rd_byte = seq_r[seq_idx(a)];
		end
		case (a)
			ADR_PORT_CFG:  rd_byte = port_cfg_r;
			ADR_REVISION:  rd_byte = REVISION_CODE;
			ADR_PART_ID:   rd_byte = PART_CODE;
			ADR_RB_SEL:    rd_byte = rb_sel_r;
			ADR_XFER_TRIG: rd_byte = {7'h00, xfer_req_r};
			ADR_S_CTL:     rd_byte = sel_buf ? s_ctl_buf_r : s_ctl_act_r; // R10
			ADR_DIRECT:    rd_byte = direct_r;
			ADR_ACTION:    rd_byte = {7'h00, sel_buf ? action_buf_r : action_act_r}; // R10
			ADR_C_LO:      rd_byte = sel_buf ? c_buf_r[7:0] : c_act_r[7:0]; // R02 R10
			ADR_C_HI:      rd_byte = sel_buf ? c_buf_r[15:8] : c_act_r[15:8]; // R02 R10
			ADR_STATUS:    rd_byte = status_act_r; // R11
			ADR_PIN_ZERO:  rd_byte = pin_zero_r;
			default:       rd_byte = rd_byte;
		endcase
	endfunction

	// Access arbitration: a busy controller owns the bank but for serial reads of read-only bytes; idle it has no access at all.
	wire        sel_buf   = rb_sel_r[BIT_RB_SEL];
	wire        in_map    = sp_addr <= ADR_SEQ_LAST; // R01
	wire        sp_wr_ok  = sp_wr && !ee_busy && in_map; // R15
	wire        ee_wr_ok  = ee_wr && ee_busy && !is_ee_excl(ee_addr); // R13 R15 R17
	wire        wr_en     = sp_wr_ok || ee_wr_ok;
	wire [15:0] wr_addr   = ee_busy ? ee_addr : sp_addr;
	wire [7:0]  wr_data   = ee_busy ? ee_wdata : sp_wdata;
	wire        sp_rd_ok  = !ee_busy || is_ro(sp_addr); // R13 R16
	logic [7:0] sp_byte;
	logic [7:0] ee_byte;

	// The readback function reads bank flops that are not its arguments.
	// A process sees them change; a continuous assignment would go stale.
	always_comb begin
		sp_byte = 8'h00; // R14
		ee_byte = 8'h00; // R14
		if (sp_rd_ok) begin
			sp_byte = rd_byte(sp_addr, sel_buf); // R16
		end
		if (ee_busy && !is_ee_excl(ee_addr)) begin
			ee_byte = rd_byte(ee_addr, sel_buf); // R17
		end
	end

	// Writes to read-only, reserved or absent addresses match nothing below.
	wire        wr_cfg    = wr_en && (wr_addr == ADR_PORT_CFG); // R19
	wire        wr_rbsel  = wr_en && (wr_addr == ADR_RB_SEL);
	wire        wr_trig   = wr_en && (wr_addr == ADR_XFER_TRIG) && wr_data[BIT_XFER];
	wire        wr_sctl   = wr_en && (wr_addr == ADR_S_CTL);
	wire        wr_direct = wr_en && (wr_addr == ADR_DIRECT);
	wire        wr_action = wr_en && (wr_addr == ADR_ACTION);
	wire        wr_clo    = wr_en && (wr_addr == ADR_C_LO);
	wire        wr_chi    = wr_en && (wr_addr == ADR_C_HI);
	wire        wr_pin    = wr_en && (wr_addr == ADR_PIN_ZERO);
	wire        wr_seq    = wr_en && is_seq(wr_addr);

	// The pin is only compared after two flops; the third flop gives the edge.
	wire        pin_edge  = pin_s2_r && !pin_s3_r && pin_zero_r[BIT_PIN_UPD];
	wire        div_tick  = div_r == DIV_LAST; // R09
	wire        s_xfer    = (upd_r == UPD_IDLE) && req_s2_r; // R08
	wire        c_xfer    = (upd_r == UPD_CWAIT) && div_tick && c_stage_r; // R09
	wire        xfer_set  = wr_trig || pin_edge; // R06

	always_comb begin
		upd_nxt = upd_r;
		case (upd_r)
			UPD_IDLE:   if (req_s2_r) begin
				upd_nxt = UPD_CWAIT;
			end
			UPD_CWAIT:  if (c_xfer) begin
				upd_nxt = UPD_DRAIN1;
			end
			// The drain lets the cleared request reach the far flop before a new look.
			UPD_DRAIN1: upd_nxt = UPD_DRAIN2;
			UPD_DRAIN2: upd_nxt = UPD_IDLE;
			default:    upd_nxt = UPD_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			upd_r       <= UPD_IDLE;
			div_r       <= '0;
			pin_s1_r    <= 1'b0;
			pin_s2_r    <= 1'b0;
			pin_s3_r    <= 1'b0;
			req_s1_r    <= 1'b0;
			req_s2_r    <= 1'b0;
			c_stage_r   <= 1'b0;
			xfer_req_r  <= 1'b0; // R21
		end else if (ce) begin
			upd_r       <= upd_nxt;
			div_r       <= div_r + 1'b1;
			pin_s1_r    <= multifunction_pin_zero;
			pin_s2_r    <= pin_s1_r;
			pin_s3_r    <= pin_s2_r;
			req_s1_r    <= xfer_req_r; // R22
			req_s2_r    <= req_s1_r; // R22
			if (upd_r != UPD_CWAIT) begin
				c_stage_r <= 1'b0;
			end else if (div_tick) begin
				c_stage_r <= 1'b1;
			end
			// A new request in the clearing cycle survives.
			if (xfer_set) begin
				xfer_req_r <= 1'b1;
			end else if (c_xfer) begin
				xfer_req_r <= 1'b0; // R22
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			port_cfg_r  <= RST_PORT_CFG;
			rb_sel_r    <= RST_RB_SEL;
			pin_zero_r  <= RST_PIN_ZERO;
			direct_r    <= RST_DIRECT;
			s_ctl_buf_r <= RST_S_CTL;
			c_buf_r     <= RST_C_PARAM; // R21
		end else if (ce) begin
			if (wr_cfg) begin
				port_cfg_r <= wr_data; // R07
			end
			if (wr_rbsel) begin
				rb_sel_r <= wr_data; // R07
			end
			if (wr_pin) begin
				pin_zero_r <= wr_data;
			end
			if (wr_direct) begin
				direct_r <= wr_data; // R05
			end
			if (wr_sctl) begin
				s_ctl_buf_r <= wr_data;
			end
			if (wr_clo) begin
				c_buf_r[7:0] <= wr_data; // R02
			end
			if (wr_chi) begin
				c_buf_r[15:8] <= wr_data; // R02
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_ctl_act_r  <= RST_S_CTL;
			c_act_r      <= RST_C_PARAM;
			status_act_r <= 8'h00;
			action_buf_r <= 1'b0;
			action_act_r <= 1'b0; // R21
		end else if (ce) begin
			if (s_xfer) begin
				s_ctl_act_r <= s_ctl_buf_r; // R04 R08
			end
			if (c_xfer) begin
				c_act_r      <= c_buf_r; // R04 R09
				status_act_r <= status_in; // R11
			end
			// A fresh write or transfer wins over a finishing action.
			if (wr_action) begin
				action_buf_r <= wr_data[BIT_ACTION];
			end else if (action_done) begin
				action_buf_r <= 1'b0; // R12
			end
			if (s_xfer && action_buf_r) begin
				action_act_r <= 1'b1; // R12
			end else if (action_done) begin
				action_act_r <= 1'b0; // R12
			end
		end
	end

	// The storage-sequence bytes are one flop array, one write port.
	genvar gi;
	generate
		for (gi = 0; gi < SEQ_DEPTH; gi++) begin : g_seq
			always_ff @(posedge clk) begin
				if (rst) begin
					seq_r[gi] <= RST_SEQ;
				end else if (ce && wr_seq && (seq_idx(wr_addr) == SEQ_IDX_W'(gi))) begin
					seq_r[gi] <= wr_data; // R03
				end
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (rst) begin
			sp_rdata_r  <= 8'h00;
			sp_rvalid_r <= 1'b0;
			ee_rdata_r  <= 8'h00;
			ee_rvalid_r <= 1'b0;
		end else if (ce) begin
			sp_rvalid_r <= sp_rd;
			ee_rvalid_r <= ee_rd;
			if (sp_rd) begin
				sp_rdata_r <= sp_byte; // R16
			end
			if (ee_rd) begin
				ee_rdata_r <= ee_byte; // R17
			end
		end
	end

	assign sp_rdata    = sp_rdata_r;
	assign sp_rvalid   = sp_rvalid_r;
	assign ee_rdata    = ee_rdata_r;
	assign ee_rvalid   = ee_rvalid_r;
	assign port_cfg    = port_cfg_r;
	assign s_ctl_act   = s_ctl_act_r;
	assign direct_out  = direct_r;
	assign action_act  = action_act_r;
	assign c_param_act = c_act_r;
	assign update_busy = xfer_req_r;
endmodule

/* File: logic/brb_pkg.sv */
// How it works
// R01: Addresses 0x0000 to 0x0E3F are decoded, each one selecting a single byte.
// R02: Multi-byte values keep their least significant bit in bit 0 of the lowest address.
// R03: Storage-sequence bytes 0x0E10 to 0x0E3F are plain bytes, outside the low-first convention.
// R04: A buffered value behind an active copy acts only after an update copies it.
// R05: A buffered register wired straight to its function acts as soon as written.
// R06: An update comes from writing 1 to bit 0 of 0x0005 or from the update pin.
// R07: Live registers act at once on write, with no update needed.
// R08: Serial-class transfers follow the serial port clock or the driving pin.
// R09: System-class transfers follow the system clock divided by 32.
// R10: Readback shows the active copy when 0x0004 bit 0 is 0, buffered when 1.
// R11: A read-only active register shows new contents only after an update captures them.
// R12: An autoclear bit acts after an update and clears when its action finishes.
// R13: When several access classes apply, the strictest one at that moment wins.
// R14: Denied or absent registers read as zero and ignore writes.
// R15: Serial port or storage controller, one at a time; a busy controller owns everything but serial reads of read-only registers.
// R16: Read-only registers stay readable from the serial port even while the controller is busy.
// R17: Excluded and read-only registers never move to or from the storage controller.
// R18: The host writes default values into unused and reserved bits.
// R19: Writes to absent addresses change nothing.
// R20: The host sends the 16-bit address high byte first after the slave address.
// R21: Reset loads every copy with its default; update and readback bits read zero.
// R22: The update request crosses two flops and clears only after its transfer.
package brb_pkg;
	localparam logic [15:0] ADR_PORT_CFG  = 16'h0000;
	localparam logic [15:0] ADR_RSVD_ONE  = 16'h0001;
	localparam logic [15:0] ADR_REVISION  = 16'h0002;
	localparam logic [15:0] ADR_PART_ID   = 16'h0003;
	localparam logic [15:0] ADR_RB_SEL    = 16'h0004;
	localparam logic [15:0] ADR_XFER_TRIG = 16'h0005;
	localparam logic [15:0] ADR_S_CTL     = 16'h0100;
	localparam logic [15:0] ADR_DIRECT    = 16'h0101;
	localparam logic [15:0] ADR_ACTION    = 16'h0102;
	localparam logic [15:0] ADR_C_LO      = 16'h0103;
	localparam logic [15:0] ADR_C_HI      = 16'h0104;
	localparam logic [15:0] ADR_STATUS    = 16'h0105;
	localparam logic [15:0] ADR_PIN_ZERO  = 16'h0200;
	localparam logic [15:0] ADR_SEQ_FIRST = 16'h0e10;
	localparam logic [15:0] ADR_SEQ_LAST  = 16'h0e3f;
	localparam int          SEQ_DEPTH     = 48;
	localparam int          SEQ_IDX_W     = 6;

	localparam logic [7:0]  RST_PORT_CFG  = 8'h10;
	localparam logic [7:0]  RST_RB_SEL    = 8'h00;
	localparam logic [7:0]  RST_S_CTL     = 8'h00;
	localparam logic [7:0]  RST_DIRECT    = 8'h00;
	localparam logic [15:0] RST_C_PARAM   = 16'h0000;
	localparam logic [7:0]  RST_PIN_ZERO  = 8'h00;
	localparam logic [7:0]  RST_SEQ       = 8'h00;

	localparam int          BIT_RB_SEL    = 0;
	localparam int          BIT_XFER      = 0;
	localparam int          BIT_ACTION    = 0;
	localparam int          BIT_PIN_UPD   = 0;

	localparam int          SYS_DIV       = 32;
	localparam int          DIV_W         = 5;
	localparam logic [4:0]  DIV_LAST      = 5'(SYS_DIV - 1);

	typedef enum logic [3:0] {
		UPD_IDLE   = 4'b0001,
		UPD_CWAIT  = 4'b0010,
		UPD_DRAIN1 = 4'b0100,
		UPD_DRAIN2 = 4'b1000
	} brb_upd_t;
endpackage

/* File: verif/brb_bank_monitor.sv */
`timescale 1ns/1ps
module brb_bank_monitor import brb_pkg::*; (
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        ce,
	// Serial port
	input wire logic        sp_rd,
	input wire logic        sp_wr,
	input wire logic [15:0] sp_addr,
	input wire logic [7:0]  sp_wdata,
	input wire logic [7:0]  sp_rdata,
	// Storage side and functions
	input wire logic        ee_busy,
	input wire logic        action_done,
	input wire logic [7:0]  port_cfg,
	input wire logic [7:0]  s_ctl_act,
	input wire logic [7:0]  direct_out,
	input wire logic        action_act,
	input wire logic [15:0] c_param_act,
	input wire logic        update_busy
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic sr;
	logic sw;
	assign sr = ce && sp_rd;
	assign sw = ce && sp_wr && !ee_busy;
	property p_deny; sr && ee_busy && sp_addr == ADR_S_CTL |=> sp_rdata == 8'h00; endproperty
	a_deny: assert property (p_deny) else $error("busy read not zero");
	property p_ro; sr && sp_addr == ADR_PART_ID |=> sp_rdata == 8'ha5; endproperty
	a_ro: assert property (p_ro) else $error("part byte wrong");
	property p_absent; sr && sp_addr > ADR_SEQ_LAST |=> sp_rdata == 8'h00; endproperty
	a_absent: assert property (p_absent) else $error("absent read not zero");
	property p_direct; sw && sp_addr == ADR_DIRECT |=> direct_out == $past(sp_wdata); endproperty
	a_direct: assert property (p_direct) else $error("direct byte late");
	property p_live; sw && sp_addr == ADR_PORT_CFG |=> port_cfg == $past(sp_wdata); endproperty
	a_live: assert property (p_live) else $error("live byte late");
	property p_trig; sw && sp_addr == ADR_XFER_TRIG && sp_wdata[0] |=> update_busy; endproperty
	a_trig: assert property (p_trig) else $error("update not pending");
	property p_hold; !update_busy |=> $stable(s_ctl_act); endproperty
	a_hold: assert property (p_hold) else $error("active copy moved");
	property p_chold; !update_busy |=> $stable(c_param_act); endproperty
	a_chold: assert property (p_chold) else $error("system copy moved");
	property p_done;
		ce && action_act && action_done && !update_busy && !ee_busy && !(sw && sp_addr == ADR_ACTION) |=> !action_act;
	endproperty
	a_done: assert property (p_done) else $error("autoclear stuck");
	// The bound covers five divider periods, room for an update with its sync and drain cycles.
	property p_bound; $rose(update_busy) |-> ##[1:160] !update_busy; endproperty
	a_bound: assert property (p_bound) else $error("update never ends");
endmodule
bind brb_bank brb_bank_monitor u_mon (.clk, .rst, .ce, .sp_rd, .sp_wr, .sp_addr, .sp_wdata, .sp_rdata,
	.ee_busy, .action_done, .port_cfg, .s_ctl_act, .direct_out, .action_act, .c_param_act, .update_busy);

/* File: verif/brb_ee_model.sv */
`timescale 1ns/1ps
module brb_ee_model (
	// Clock
	input wire logic        clk,
	// Storage controller access
	output logic            ee_busy,
	output logic            ee_rd,
	output logic            ee_wr,
	output logic     [15:0] ee_addr,
	output logic     [7:0]  ee_wdata,
	input wire logic [7:0]  ee_rdata
);
	initial begin
		ee_busy = 0;
		ee_rd = 0;
		ee_wr = 0;
		ee_addr = 16'h0000;
		ee_wdata = 8'h00;
	end
	// Busy is raised with the first access and kept until idle, so it owns the bank.
	task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q, input int gap);
		repeat (gap) @(negedge clk);
		@(negedge clk);
		ee_busy = 1;
		ee_rd = !w;
		ee_wr = w;
		ee_addr = a;
		ee_wdata = d;
		@(negedge clk);
		ee_rd = 0;
		ee_wr = 0;
		ee_addr = ~a;
		ee_wdata = ~d;
		q = ee_rdata;
	endtask
	task automatic idle;
		@(negedge clk);
		ee_busy = 0;
	endtask
endmodule

/* File: verif/brb_bank_tb.sv */
`timescale 1ns/1ps
module brb_bank_tb import brb_pkg::*;;
	logic        clk = 0, rst = 1, ce = 1, sp_rd = 0, sp_wr = 0, pin = 0, done = 0;
	logic [15:0] sp_addr = 0, a;
	logic [7:0]  sp_wdata = 0, status_in = 0, v, w, q;
	logic [31:0] seed = 32'h97e0d71d;
	int          failures = 0, n_compared = 0;
	wire logic [7:0]  sp_rdata, ee_rdata, ee_wdata, port_cfg, s_ctl_act, direct_out;
	wire logic [15:0] ee_addr, c_param_act;
	wire logic        sp_rvalid, ee_busy, ee_rd, ee_wr, ee_rvalid, action_act, update_busy;
	always #4 clk = ~clk;
	brb_bank dut (.clk, .rst, .ce, .sp_rd, .sp_wr, .sp_addr, .sp_wdata, .sp_rdata, .sp_rvalid,
		.ee_busy, .ee_rd, .ee_wr, .ee_addr, .ee_wdata, .ee_rdata, .ee_rvalid,
		.multifunction_pin_zero(pin), .action_done(done), .status_in, .port_cfg, .s_ctl_act,
		.direct_out, .action_act, .c_param_act, .update_busy);
	brb_ee_model p (.clk, .ee_busy, .ee_rd, .ee_wr, .ee_addr, .ee_wdata, .ee_rdata);
	function automatic logic [7:0] rnd;
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [15:0] ad, input logic [7:0] d);
		@(negedge clk);
		sp_wr = 1;
		sp_addr = ad;
		sp_wdata = d;
		@(negedge clk);
		sp_wr = 0;
		sp_addr = ~ad;
		sp_wdata = ~d;
	endtask
	task automatic rd(input logic [15:0] ad, input logic [7:0] e);
		@(negedge clk);
		sp_rd = 1;
		sp_addr = ad;
		@(negedge clk);
		sp_rd = 0;
		sp_addr = ~ad;
		chk({7'h00, sp_rvalid, sp_rdata}, {8'h01, e});
	endtask
	task automatic upd_wait;
		for (int k = 0; k < 200 && update_busy !== 1'b0; k++) @(negedge clk);
		chk(update_busy, 16'h0000);
	endtask
	task automatic conclude;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#200000;
		failures++;
		conclude();
	end
	initial begin
		repeat (10) @(negedge clk);
		rst = 0;
		rd(ADR_PORT_CFG, RST_PORT_CFG);
		rd(ADR_RB_SEL, 8'h00);
		rd(ADR_XFER_TRIG, 8'h00);
		rd(ADR_REVISION, 8'h5a);
		wr(ADR_PART_ID, 8'h00);
		rd(ADR_PART_ID, 8'ha5);
		wr(ADR_RSVD_ONE, 8'h3c);
		rd(ADR_RSVD_ONE, 8'h00);
		wr(ADR_SEQ_FIRST, 8'h3c);
		for (int i = 0; i < 8; i++) begin
			v = rnd();
			w = rnd();
			a = ADR_SEQ_FIRST + 16'(v % 8'd48);
			wr(a, w);
			rd(a, w);
			wr(16'h0e40 + {8'h00, v}, w);
			rd(16'h0e40 + {8'h00, v}, 8'h00);
		end
		v = rnd();
		w = rnd();
		status_in = rnd();
		q = status_in;
		wr(ADR_S_CTL, v);
		wr(ADR_C_LO, w);
		wr(ADR_C_HI, ~w);
		wr(ADR_ACTION, 8'h01);
		rd(ADR_S_CTL, 8'h00);
		chk(s_ctl_act, 16'h0000);
		wr(ADR_RB_SEL, 8'h01);
		rd(ADR_S_CTL, v);
		wr(ADR_RB_SEL, 8'h00);
		wr(ADR_XFER_TRIG, 8'h01);
		upd_wait();
		chk(s_ctl_act, v);
		chk(c_param_act, {~w, w});
		chk(action_act, 16'h0001);
		status_in = ~q;
		rd(ADR_STATUS, q);
		@(negedge clk) done = 1;
		@(negedge clk) done = 0;
		chk(action_act, 16'h0000);
		wr(ADR_PIN_ZERO, 8'h01);
		v = rnd();
		wr(ADR_S_CTL, v);
		@(negedge clk) pin = 1;
		repeat (4) @(negedge clk);
		pin = 0;
		upd_wait();
		chk(s_ctl_act, v);
		wr(ADR_DIRECT, v);
		chk(direct_out, v);
		wr(ADR_PORT_CFG, 8'h18);
		chk(port_cfg, 8'h18);
		ce = 0;
		wr(ADR_DIRECT, ~v);
		chk(direct_out, {8'h00, v});
		ce = 1;
		p.xfer(1, ADR_DIRECT, ~v, q, 2);
		chk(direct_out, {8'h00, ~v});
		wr(ADR_DIRECT, v);
		chk(direct_out, {8'h00, ~v});
		rd(ADR_DIRECT, 8'h00);
		rd(ADR_S_CTL, 8'h00);
		rd(ADR_PART_ID, 8'ha5);
		p.xfer(0, ADR_DIRECT, 8'h00, q, 0);
		chk(q, {8'h00, ~v});
		p.xfer(0, ADR_SEQ_FIRST, 8'h00, q, 0);
		chk({7'h00, ee_rvalid, q}, 16'h0100);
		p.xfer(0, ADR_STATUS, 8'h00, q, 0);
		chk({7'h00, ee_rvalid, q}, 16'h0100);
		p.idle();
		conclude();
	end
endmodule
